// *** rtl/backlight_fault_and_serial_ctrl.sv ***
`timescale 1ns/100ps
module backlight_fault_and_serial_ctrl import bl_pkg::*; #(
  parameter int unsigned MS_CYCLES = MS_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic scl_pin,
  input wire logic sda_pin,
  input wire logic enable_io_supply_pin,
  input wire logic pwm_in_pin,
  input wire analog_ind_t ind,
  output logic sda_out,
  output logic sda_oe_n,
  output logic led_out_en,
  output logic boost_en,
  output logic dim_pwm,
  output logic active
);
  // ==========================================
  // pin sampling
  logic [3:0] pins;
  logic [3:0] pins_d;
  logic scl, sda, en, pwm_lvl;
  logic scl_rise, scl_fall, start_c, stop_c;

  pin_sync #(.W(4), .RST(PIN_RST)) u_sync (
    .clk(clk),
    .srst(srst),
    .d({pwm_in_pin, enable_io_supply_pin, sda_pin, scl_pin}),
    .q(pins)
  );

  assign scl = pins[0];
  assign sda = pins[1];
  assign en = pins[2];
  assign pwm_lvl = pins[3];

  always_ff @(posedge clk) begin
    if (srst) begin
      pins_d <= PIN_RST;
    end else begin
      pins_d <= pins;
    end
  end

  // the clock line is only ever sampled, there is no driver for it [RQ16]
  assign scl_rise = scl & ~pins_d[0];
  assign scl_fall = ~scl & pins_d[0];
  assign start_c = scl & pins_d[0] & pins_d[1] & ~sda; // [RQ19]
  assign stop_c = scl & pins_d[0] & ~pins_d[1] & sda; // [RQ19]

  // ==========================================
  // serial slave
  link_state_t st;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] tx;
  logic [7:0] ptr;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic wr_stb, rd_stb, rd_mode, mack;
  logic addr_match;

  assign addr_match = shreg[7:1] == SLAVE_ADDR; // [RQ23]

  always_ff @(posedge clk) begin
    if (srst || !en) begin
      st <= ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      tx <= 8'hFF;
      ptr <= 8'h00;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      rd_mode <= 1'b0;
      mack <= 1'b0;
      sda_oe_n <= 1'b1;
      sda_out <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      sda_out <= 1'b0;
      if (start_c) begin
        // also a repeated start: restart address phase, keep pointer [RQ20]
        st <= ST_ADDR;
        bit_cnt <= 4'h0;
        sda_oe_n <= 1'b1;
      end else if (stop_c) begin
        // data edge while clock high ends any transfer in flight [RQ17]
        st <= ST_IDLE;
        sda_oe_n <= 1'b1;
      end else begin
        case (st)
          ST_ADDR, ST_PTR, ST_WR: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda}; // [RQ17] [RQ18]
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == BITS_PER_BYTE) begin
              bit_cnt <= 4'h0;
              if (st == ST_ADDR) begin
                if (addr_match) begin
                  sda_oe_n <= 1'b0; // [RQ21] [RQ23]
                  rd_mode <= shreg[0];
                  st <= ST_ADDR_ACK;
                end else begin
                  st <= ST_IDLE;
                end
              end else if (st == ST_PTR) begin
                ptr <= shreg; // [RQ24]
                sda_oe_n <= 1'b0; // [RQ21]
                st <= ST_PTR_ACK;
              end else begin
                wr_addr <= ptr;
                wr_data <= shreg;
                wr_stb <= 1'b1;
                sda_oe_n <= 1'b0; // [RQ21]
                st <= ST_WR_ACK;
              end
            end
          end
          ST_ADDR_ACK, ST_PTR_ACK, ST_WR_ACK: begin
            if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (st == ST_WR_ACK) begin
                ptr <= ptr + 8'h01; // [RQ24]
              end
              if (st == ST_ADDR_ACK && rd_mode) begin
                tx <= {rd_data[6:0], 1'b1};
                sda_oe_n <= rd_data[7]; // [RQ18]
                rd_stb <= 1'b1;
                st <= ST_RD;
              end else begin
                sda_oe_n <= 1'b1;
                st <= (st == ST_ADDR_ACK) ? ST_PTR : ST_WR;
              end
            end
          end
          ST_RD: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt == BITS_PER_BYTE) begin
                sda_oe_n <= 1'b1; // [RQ21]
                st <= ST_RD_ACK;
              end else begin
                sda_oe_n <= tx[7]; // [RQ18]
                tx <= {tx[6:0], 1'b1};
              end
            end
          end
          ST_RD_ACK: begin
            if (scl_rise) begin
              mack <= ~sda;
              if (!sda) begin
                ptr <= ptr + 8'h01;
              end
            end else if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (mack) begin
                tx <= {rd_data[6:0], 1'b1};
                sda_oe_n <= rd_data[7];
                rd_stb <= 1'b1;
                st <= ST_RD;
              end else begin
                st <= ST_IDLE; // [RQ22]
              end
            end
          end
          default: begin
            st <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================
  // register file
  logic [7:0] brightness;
  logic [7:0] dev_ctrl;
  logic [7:0] cfg_uv;
  logic [7:0] cfg_slope;
  logic [7:0] cfg_dither;
  logic [7:0] fault_status;
  logic cfg_wr_ok;

  // lock keeps a running backlight safe from stray configuration writes
  assign cfg_wr_ok = wr_stb && !active; // [RQ15]

  always_ff @(posedge clk) begin
    if (srst) begin
      brightness <= REG_RST;
      dev_ctrl <= REG_RST;
      cfg_uv <= REG_RST;
      cfg_slope <= REG_RST;
      cfg_dither <= REG_RST;
    end else if (wr_stb) begin
      case (wr_addr)
        ADDR_BRT: brightness <= wr_data;
        ADDR_CTRL: dev_ctrl <= wr_data;
        ADDR_CFG_UV: if (cfg_wr_ok) cfg_uv <= wr_data; // [RQ15]
        ADDR_CFG_SLOPE: if (cfg_wr_ok) cfg_slope <= wr_data; // [RQ15]
        ADDR_CFG_DITHER: if (cfg_wr_ok) cfg_dither <= wr_data; // [RQ15]
        default: ;
      endcase
    end
  end

  always_comb begin
    case (ptr)
      ADDR_BRT: rd_data = brightness;
      ADDR_CTRL: rd_data = dev_ctrl;
      ADDR_STATUS: rd_data = fault_status; // [RQ12]
      ADDR_CFG_UV: rd_data = cfg_uv;
      ADDR_CFG_SLOPE: rd_data = cfg_slope;
      ADDR_CFG_DITHER: rd_data = cfg_dither;
      default: rd_data = 8'h00;
    endcase
  end

  // ==========================================
  // faults
  logic uv_cond, open_cond, short_cond, rd_clear;
  logic [5:0] optimised;
  logic [7:0] fault_set;
  logic [7:0] fault_clr;

  assign uv_cond = cfg_uv[UV_ON] && (cfg_uv[UV_SEL] ? ind.uv_high : ind.uv_low); // [RQ7]
  assign open_cond = ind.boost_at_max && (|ind.low_cmp); // [RQ5]
  assign optimised = ~(ind.low_cmp | ind.mid_cmp | ind.high_cmp);
  // an optimised string cannot have high asserted, so the two are distinct
  assign short_cond = (|optimised) && (|ind.high_cmp); // [RQ6]
  assign rd_clear = rd_stb && ptr == ADDR_STATUS; // [RQ12]
  assign fault_set = {open_cond, short_cond, 3'b000, ind.ocp, ind.tsd, uv_cond};
  assign fault_clr = {{7{rd_clear}}, rd_clear || !en}; // [RQ9]

  // set wins over clear, so a lasting fault reappears after a read
  always_ff @(posedge clk) begin
    if (srst) begin
      fault_status <= REG_RST;
    end else begin
      fault_status <= (fault_status & ~fault_clr) | fault_set; // [RQ25] [RQ8] [RQ10]
    end
  end

  // ==========================================
  // mode and power outputs
  logic [16:0] pwm_idle;
  logic pwm_active, bl_on;

  always_ff @(posedge clk) begin
    if (srst) begin
      pwm_idle <= 17'h1FFFF;
    end else if (pwm_lvl != pins_d[3]) begin
      pwm_idle <= 17'h00000;
    end else if (pwm_idle != 17'h1FFFF) begin
      pwm_idle <= pwm_idle + 17'h00001;
    end
  end

  assign pwm_active = 32'(pwm_idle) < MS_CYCLES;
  assign bl_on = (dev_ctrl[CTRL_SRC +: 2] == 2'b00) ? pwm_active : dev_ctrl[CTRL_ON]; // [RQ14]

  always_ff @(posedge clk) begin
    if (srst) begin
      active <= 1'b0;
      led_out_en <= 1'b0;
      boost_en <= 1'b0;
    end else begin
      active <= en && bl_on; // [RQ13] [RQ14]
      led_out_en <= en && bl_on && !uv_cond && !ind.tsd; // [RQ8] [RQ11]
      boost_en <= en && bl_on && !uv_cond && !ind.tsd && !ind.ocp; // [RQ8] [RQ10] [RQ11]
    end
  end

  // ==========================================
  // slope
  logic [10:0] level;
  logic [10:0] target;
  logic [23:0] slope_cnt;
  logic [23:0] step_cycles;
  logic [2:0] slope_code;
  logic sloping;

  assign slope_code = cfg_slope[SLOPE_POS +: 3];
  assign target = {brightness, 3'b000};
  assign sloping = level != target;

  always_comb begin
    step_cycles = 24'((64'(SLOPE_MS[slope_code]) * 64'(MS_CYCLES)) / 64'(RAMP_STEPS));
    if (step_cycles == 24'h000000) begin
      step_cycles = 24'h000001;
    end
  end

  // one fractional step per interval, so a full-scale swing takes the set time
  always_ff @(posedge clk) begin
    if (srst) begin
      level <= 11'h000;
      slope_cnt <= 24'h000000;
    end else if (!sloping) begin
      slope_cnt <= 24'h000000;
    end else if (slope_code == 3'h0) begin
      level <= target; // [RQ1]
    end else if (slope_cnt >= step_cycles - 24'h000001) begin
      slope_cnt <= 24'h000000;
      level <= (level < target) ? level + 11'h001 : level - 11'h001; // [RQ1]
    end else begin
      slope_cnt <= slope_cnt + 24'h000001;
    end
  end

  // ==========================================
  // dither and dimming pulse
  logic [7:0] pwm_cnt;
  logic [2:0] pulse_idx;
  logic [8:0] width;
  logic [1:0] depth;
  logic [2:0] frac_d;
  logic [2:0] idx_mask;
  logic use_dither, stretch;

  assign depth = cfg_dither[DITHER_POS +: 2]; // [RQ2]
  assign use_dither = depth != 2'b00 && (sloping || cfg_dither[STEADY_DITHER]); // [RQ3]
  assign frac_d = level[2:0] >> (3'd3 - {1'b0, depth}); // [RQ2]
  assign idx_mask = 3'((4'h1 << depth) - 4'h1);
  // pulses 0..frac-1 of each group of 2^depth get one extra step [RQ4]
  assign stretch = use_dither && ((pulse_idx & idx_mask) < frac_d); // [RQ4]

  always_ff @(posedge clk) begin
    if (srst) begin
      pwm_cnt <= 8'h00;
      pulse_idx <= 3'h0;
      width <= 9'h000;
      dim_pwm <= 1'b0;
    end else begin
      pwm_cnt <= pwm_cnt + 8'h01;
      if (pwm_cnt == 8'hFF) begin
        pulse_idx <= pulse_idx + 3'h1;
        width <= {1'b0, level[10:3]} + {8'h00, stretch}; // [RQ4]
      end
      dim_pwm <= led_out_en && ({1'b0, pwm_cnt} < width) &&
                 (dev_ctrl[CTRL_SRC +: 2] != 2'b00 || pwm_lvl);
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  status_clear_a: assert property ( // [RQ12]
    (rd_clear && fault_set == 8'h00) |=> fault_status == 8'h00)
    else $error("status not cleared by read");
  open_flag_a: assert property ( // [RQ5]
    open_cond |=> fault_status[ST_OPEN])
    else $error("open flag missing");
  short_flag_a: assert property ( // [RQ6]
    (|optimised && |ind.high_cmp) |=> fault_status[ST_SHORT])
    else $error("short flag missing");
  uv_off_a: assert property ( // [RQ8]
    uv_cond |=> !led_out_en && !boost_en && fault_status[ST_UV])
    else $error("undervoltage did not stop outputs");
  ocp_boost_a: assert property ( // [RQ10]
    ind.ocp |=> !boost_en && fault_status[ST_OCP])
    else $error("overcurrent did not stop boost");
  tsd_off_a: assert property ( // [RQ11]
    ind.tsd |=> !led_out_en && !boost_en)
    else $error("thermal shutdown ignored");
  shutdown_a: assert property ( // [RQ13]
    !en [*2] |-> !active && !led_out_en)
    else $error("active while enable low");
  uv_pin_clear_a: assert property ( // [RQ9]
    (!en && !uv_cond) |=> !fault_status[ST_UV])
    else $error("undervoltage flag kept with enable low");
  cfg_lock_a: assert property ( // [RQ15]
    (wr_stb && active) |=> $stable(cfg_uv) && $stable(cfg_slope) && $stable(cfg_dither))
    else $error("config written in active mode");
  addr_ack_a: assert property ( // [RQ21]
    (st == ST_ADDR && scl_fall && bit_cnt == BITS_PER_BYTE && addr_match && !start_c && !stop_c)
      |=> !sda_oe_n && st == ST_ADDR_ACK)
    else $error("address not acknowledged");
  slope_jump_a: assert property ( // [RQ1]
    (slope_code == 3'h0 && sloping) |=> level == $past(target))
    else $error("zero slope did not jump");
  never_drive_high_a: assert property ( // [RQ16]
    !sda_out)
    else $error("data line driven high");

  status_read_c: cover property (rd_clear ##1 fault_status == 8'h00);
  reg_write_c: cover property (wr_stb && wr_addr == ADDR_BRT);
  slope_run_c: cover property (sloping && slope_code != 3'h0 ##1 sloping);
  dither_c: cover property (stretch && pwm_cnt == 8'hFF);
endmodule

// *** rtl/bl_pkg.sv ***
// Operation
// [RQ1] brightness ramps over a 3-bit selected time, same up and down
// [RQ2] dither depth of zero to three extra bits from a 2-bit field
// [RQ3] a bit selects dithering in steady state or only while sloping
// [RQ4] three-bit dither lengthens one pulse in eight by one step
// [RQ5] open flag when boost request is at maximum and a low comparator asserts
// [RQ6] short flag when one string is optimised and another has high asserted
// [RQ7] lockout off when disabled, select picks low or high threshold
// [RQ8] undervoltage stops leds and boost, sets flag, restarts on recovery
// [RQ9] undervoltage flag cleared by enable pin low or status read
// [RQ10] overcurrent stops boost, sets flag, restarts once current drops
// [RQ11] thermal indication stops leds and boost until it recovers
// [RQ12] reading fault status reports causes and clears latched flags
// [RQ13] shutdown while enable pin is low
// [RQ14] backlight enabled by on bit, or by pwm activity when source is 00
// [RQ15] configuration writes are blocked in active mode
// [RQ16] device is a serial slave only and never drives the clock line
// [RQ17] data sampled while clock high; change while high aborts transfer
// [RQ18] bytes are eight bits, msb first, each followed by an ack slot
// [RQ19] master makes start and stop by data edges while clock is high
// [RQ20] repeated start accepted in the middle of a transaction
// [RQ21] receiver holds data low through the ninth clock high phase
// [RQ22] master ends a read by leaving data high in the last ack slot
// [RQ23] device answers slave address 2Ch with direction bit after it
// [RQ24] first written byte is the pointer, incremented after each data byte
// [RQ25] a fault still present after a read sets its flag again
package bl_pkg;
  // ==========================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned RAMP_STEPS = 2048;
  localparam int unsigned SLOPE_MS [8] = '{0, 1, 2, 50, 100, 200, 300, 500};
  // ==========================================
  // register map
  localparam logic [7:0] ADDR_BRT = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h01;
  localparam logic [7:0] ADDR_STATUS = 8'h02;
  localparam logic [7:0] ADDR_CFG_UV = 8'hA2;
  localparam logic [7:0] ADDR_CFG_SLOPE = 8'hA3;
  localparam logic [7:0] ADDR_CFG_DITHER = 8'hA4;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam int CTRL_ON = 0;
  localparam int CTRL_SRC = 1;
  localparam int UV_ON = 5;
  localparam int UV_SEL = 4;
  localparam int SLOPE_POS = 4;
  localparam int STEADY_DITHER = 2;
  localparam int DITHER_POS = 0;
  localparam int ST_OPEN = 7;
  localparam int ST_SHORT = 6;
  localparam int ST_OCP = 2;
  localparam int ST_TSD = 1;
  localparam int ST_UV = 0;
  // ==========================================
  // serial link
  localparam logic [6:0] SLAVE_ADDR = 7'h2C;
  localparam logic [3:0] PIN_RST = 4'h3;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001, ST_ADDR = 9'h002, ST_ADDR_ACK = 9'h004,
    ST_PTR = 9'h008, ST_PTR_ACK = 9'h010, ST_WR = 9'h020,
    ST_WR_ACK = 9'h040, ST_RD = 9'h080, ST_RD_ACK = 9'h100
  } link_state_t;
  typedef struct packed {
    logic [5:0] low_cmp;
    logic [5:0] mid_cmp;
    logic [5:0] high_cmp;
    logic boost_at_max;
    logic uv_low;
    logic uv_high;
    logic ocp;
    logic tsd;
  } analog_ind_t;
endpackage

// *** rtl/pin_sync.sv ***
`timescale 1ns/100ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  // a change is accepted only when the second and third stages agree
  always_ff @(posedge clk) begin
    if (srst) begin
      s1 <= RST;
      s2 <= RST;
      s3 <= RST;
      q <= RST;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < W; i++) begin
        if (s2[i] == s3[i]) begin
          q[i] <= s3[i];
        end
      end
    end
  end
endmodule

// *** sim/i2c_master_model.sv ***
`timescale 1ns/100ps
module i2c_master_model (
  output logic scl,
  output logic sda_o,
  input wire logic sda
);
  // ==========================================
  // two-wire master, 200 ns clock period
  localparam int HALF = 100;
  // uneven duty: the device sees the clock through a synchroniser, so its
  // data and ack edges land about 100 ns after a clock fall and need a long low phase
  localparam int LOW = 140;
  localparam int HIGH = 60;
  // sda_o of 1 releases the line to the pull-up; scl stands high between frames
  initial begin
    scl = 1'b1;
    sda_o = 1'b1;
  end
  task automatic bit_x(input logic b, output logic r);
    #20 sda_o = b;
    #(LOW - 20) scl = 1'b1;
    // sample late in the high phase: the device answers through a synchroniser
    #(HIGH - 10) r = sda;
    #10 scl = 1'b0;
  endtask
  task automatic start();
    #7;
    #(HALF / 2) sda_o = 1'b1;
    #(HALF / 2) scl = 1'b1;
    #HALF sda_o = 1'b0;
    #HALF scl = 1'b0;
  endtask
  task automatic stop();
    #(HALF / 2) sda_o = 1'b0;
    #(HALF / 2) scl = 1'b1;
    #HALF sda_o = 1'b1;
    #HALF;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(last, r);
  endtask
endmodule

// *** sim/tb_backlight_fault_and_serial_ctrl.sv ***
`timescale 1ns/100ps
module tb_backlight_fault_and_serial_ctrl;
  import bl_pkg::*;
  // ==========================================
  // pins and design
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic en = 1'b0;
  logic pwm = 1'b0;
  analog_ind_t ind = '0;
  logic scl, sda_m, sda_out, sda_oe_n, led_en, boost_en, dim, act, a;
  wire sda;
  int err_count = 0;
  int n_checks = 0;
  int cnt;
  logic [7:0] rq[$];
  logic [7:0] wq[$];
  localparam logic [7:0] FS [8] = '{8'h02, 8'h04, 8'h80, 8'h00, 8'h40, 8'h00, 8'h00, 8'h01};
  localparam logic [1:0] FO [8] = '{2'h0, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 2'h0};
  // open-drain wire with pull-up
  assign sda = sda_m & (sda_oe_n | sda_out);
  always #12.5 clk = ~clk;
  backlight_fault_and_serial_ctrl #(.MS_CYCLES(2048)) dut_u (
    .clk(clk), .srst(srst), .scl_pin(scl), .sda_pin(sda),
    .enable_io_supply_pin(en), .pwm_in_pin(pwm), .ind(ind),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .led_out_en(led_en),
    .boost_en(boost_en), .dim_pwm(dim), .active(act));
  i2c_master_model m_u (.scl(scl), .sda_o(sda_m), .sda(sda));
  // ==========================================
  // helpers
  task cyc(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] p);
    m_u.start();
    m_u.wbyte({SLAVE_ADDR, 1'b0}, a);
    chk(8'(a), 8'h01);
    m_u.wbyte(p, a);
    foreach (wq[i]) m_u.wbyte(wq[i], a);
    m_u.stop();
  endtask
  task rd(input logic [7:0] p, input int n);
    logic [7:0] b;
    rq = {};
    m_u.start();
    m_u.wbyte({SLAVE_ADDR, 1'b0}, a);
    m_u.wbyte(p, a);
    m_u.start();
    m_u.wbyte({SLAVE_ADDR, 1'b1}, a);
    for (int i = 0; i < n; i++) begin
      m_u.rbyte(i == n - 1, b);
      rq.push_back(b);
    end
    m_u.stop();
  endtask
  task rchk(input logic [7:0] p, input logic [7:0] e);
    rd(p, 1);
    chk(rq[0], e);
  endtask
  function automatic analog_ind_t mk(input int k);
    analog_ind_t v;
    v = '0;
    case (k)
      0: v.tsd = 1'b1;
      1: v.ocp = 1'b1;
      2: v = '{low_cmp: 6'h01, boost_at_max: 1'b1, default: '0};
      3: v.low_cmp = 6'h01;
      4: v.high_cmp = 6'h02;
      5: v.high_cmp = 6'h3F;
      6: v.uv_high = 1'b1;
      default: v = '{uv_low: 1'b1, uv_high: 1'b1, default: '0};
    endcase
    return v;
  endfunction
  task uvcase(input logic [7:0] cfg, input analog_ind_t v, input logic [7:0] e);
    wq = '{8'h00};
    wr(ADDR_CTRL);
    wq = '{cfg};
    wr(ADDR_CFG_UV);
    wq = '{8'h03};
    wr(ADDR_CTRL);
    ind = v;
    cyc(6);
    ind = '0;
    cyc(6);
    rchk(ADDR_STATUS, e);
  endtask
  task summarize();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ==========================================
  // watchdog, about four times the expected run
  initial begin
    #2000000;
    err_count++;
    summarize();
  end
  // ==========================================
  // tests
  initial begin
    cyc(3);
    srst = 1'b0;
    chk(8'({sda_oe_n, led_en, boost_en, act}), 8'h08);
    en = 1'b1;
    cyc(10);
    rd(ADDR_BRT, 3);
    foreach (rq[i]) chk(rq[i], REG_RST);
    rchk(8'h10, 8'h00);
    m_u.start();
    m_u.wbyte({SLAVE_ADDR + 7'h01, 1'b0}, a);
    m_u.stop();
    chk(8'(a), 8'h00);
    wq = '{8'h20, 8'h00, 8'h00};
    wr(ADDR_CFG_UV);
    rd(ADDR_CFG_UV, 3);
    foreach (rq[i]) chk(rq[i], wq[i]);
    wq = '{8'h55, 8'h03};
    wr(ADDR_BRT);
    cyc(8);
    chk(8'({act, led_en, boost_en}), 8'h07);
    wq = '{8'h70};
    wr(ADDR_CFG_SLOPE);
    rchk(ADDR_CFG_SLOPE, 8'h00);
    // slope code 0 jumps, so one full period shows the final width
    cyc(600);
    cnt = 0;
    repeat (256) begin
      cyc(1);
      cnt += int'(dim);
    end
    chk(8'(cnt), 8'h55);
    m_u.start();
    m_u.wbyte({SLAVE_ADDR, 1'b0}, a);
    m_u.wbyte(ADDR_BRT, a);
    repeat (3) m_u.bit_x(1'b1, a);
    m_u.stop();
    rchk(ADDR_BRT, 8'h55);
    for (int k = 0; k < 8; k++) begin
      ind = mk(k);
      cyc(6);
      chk(8'({led_en, boost_en}), 8'(FO[k]));
      rchk(ADDR_STATUS, FS[k]);
      ind = '0;
      cyc(6);
      chk(8'({led_en, boost_en}), 8'h03);
      rchk(ADDR_STATUS, FS[k]);
      rchk(ADDR_STATUS, 8'h00);
    end
    ind = mk(7);
    cyc(6);
    ind = '0;
    cyc(4);
    en = 1'b0;
    cyc(8);
    chk(8'(act), 8'h00);
    m_u.start();
    m_u.wbyte({SLAVE_ADDR, 1'b0}, a);
    m_u.stop();
    chk(8'(a), 8'h00);
    en = 1'b1;
    cyc(10);
    rchk(ADDR_STATUS, 8'h00);
    uvcase(8'h30, mk(6), 8'h01);
    uvcase(8'h00, mk(7), 8'h00);
    wq = '{8'h01};
    wr(ADDR_CTRL);
    cyc(8);
    chk(8'(act), 8'h00);
    repeat (4) begin
      pwm = ~pwm;
      cyc(40);
    end
    chk(8'(act), 8'h01);
    cyc(4200);
    chk(8'(act), 8'h00);
    summarize();
  end
endmodule
